// ---- adc_result_cfg.svh ----
// Register offsets, field positions, reset values and codes of the converter result block.
`ifndef ADC_RESULT_CFG_SVH
`define ADC_RESULT_CFG_SVH

// Byte offsets of the registers on the register bus.
`define ADC_OFS_CTRL_ZERO 5'h00
`define ADC_OFS_CTRL_ONE 5'h04
`define ADC_OFS_RES_HIGH 5'h08
`define ADC_OFS_RES_LOW 5'h0C

// Field positions in converter_control_zero.
`define ADC_C0_FORMAT 7
`define ADC_C0_VREF_NEG 6
`define ADC_C0_VREF_POS 5
`define ADC_C0_CHAN_HI 4
`define ADC_C0_CHAN_LO 2
`define ADC_C0_GO 1
`define ADC_C0_ENABLE 0

// Field positions in converter_control_one.
`define ADC_C1_CLKSEL_HI 6
`define ADC_C1_CLKSEL_LO 4

// Reset values and writable masks.
`define ADC_C0_RESET 8'h00
`define ADC_C1_RESET 8'h00
`define ADC_C1_MASK 8'h70

// Bus answer codes.
`define ADC_RESP_OKAY 2'h0
`define ADC_RESP_SLVERR 2'h2

`endif

// ---- adc_fmt_pkg.sv ----
// Types shared by the converter result block and its packer.
package adc_fmt_pkg;

  // Write channel handler states.
  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;

  // Read channel handler states.
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;

  // Completed conversion offered by the converter core.
  typedef struct packed {
    logic done;
    logic [9:0] value;
  } conv_result_t;

  // Control fields driven to the converter core.
  typedef struct packed {
    logic enable;
    logic go;
    logic [2:0] channel;
    logic vref_pos;
    logic vref_neg;
    logic [2:0] clk_sel;
  } conv_ctrl_t;

  // The two result bytes as software sees them.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

endpackage

// ---- result_packer.sv ----
// Justifies a 10-bit conversion into the high and low result bytes.
`timescale 1ns/1ps
`default_nettype none

module result_packer (
  // Conversion in.
  input wire logic [9:0] value,
  input wire logic right_justify,
  // Byte pair out.
  output adc_fmt_pkg::result_pair_t pair
);
  import adc_fmt_pkg::*;

  // Reserved bits are filled with zero so software never sees stale data there.
  always_comb begin
    if (right_justify) begin
      pair.high = {6'h00, value[9:8]};
      pair.low = value[7:0];
    end else begin
      pair.high = value[9:2];
      pair.low = {value[1:0], 6'h00};
    end
  end

endmodule // result_packer

`default_nettype wire

// ---- adc_result_formatter.sv ----
// Converter control and result registers behind an AXI4-Lite slave.
//
// Overview of operation
// - With left justification, result bits 9..2 go to high byte bits 7..0.
// - With left justification, result bits 1..0 go to low byte bits 7..6 and bits 5..0 are reserved.
// - With right justification, result bits 9..8 go to high byte bits 1..0 and bits 7..2 are reserved.
// - With right justification, result bits 7..0 fill the whole low byte.
//
// The acquisition wait is left to software: a start written too early converts a half-settled input.
// Result bytes have no reset, which keeps the register file small; they read unknown until filled.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_cfg.svh"

module adc_result_formatter #(
  parameter int ADDR_W = 5
) (
  // Clock, reset and freeze.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address and data.
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Converter core.
  input wire adc_fmt_pkg::conv_result_t conv_in,
  output adc_fmt_pkg::conv_ctrl_t conv_ctrl
);
  import adc_fmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Register selects; the spare code marks an unmapped address.
  localparam logic [2:0] SEL_C0 = 3'h0;
  localparam logic [2:0] SEL_C1 = 3'h1;
  localparam logic [2:0] SEL_HI = 3'h2;
  localparam logic [2:0] SEL_LO = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;

  // Maps a byte address to a register select; anything else is unmapped.
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a == ADDR_W'(`ADC_OFS_CTRL_ZERO)) s = SEL_C0;
    else if (a == ADDR_W'(`ADC_OFS_CTRL_ONE)) s = SEL_C1;
    else if (a == ADDR_W'(`ADC_OFS_RES_HIGH)) s = SEL_HI;
    else if (a == ADDR_W'(`ADC_OFS_RES_LOW)) s = SEL_LO;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // Registers with their next values.
  logic [7:0] ctrl0_ff, nxt_ctrl0;
  logic [7:0] ctrl1_ff, nxt_ctrl1;
  logic [7:0] res_hi_ff, nxt_res_hi;
  logic [7:0] res_lo_ff, nxt_res_lo;
  wr_state_t wr_state_ff, nxt_wr_state;
  logic aw_held_ff, nxt_aw_held;
  logic [2:0] aw_sel_ff, nxt_aw_sel;
  logic w_held_ff, nxt_w_held;
  logic [7:0] wbyte_ff, nxt_wbyte;
  logic wlane_ff, nxt_wlane;
  logic [1:0] bresp_ff, nxt_bresp;
  rd_state_t rd_state_ff, nxt_rd_state;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // Helper nets of the write path and the packed result.
  logic aw_take, w_take, aw_have, w_have, commit;
  logic [2:0] wr_sel;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic go_set;
  result_pair_t packed_res;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels.

  // Address and data are taken in either order and parked until both are here.
  assign awready = (wr_state_ff == WR_IDLE) && !aw_held_ff;
  assign wready = (wr_state_ff == WR_IDLE) && !w_held_ff;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign aw_have = aw_held_ff || aw_take;
  assign w_have = w_held_ff || w_take;
  assign commit = (wr_state_ff == WR_IDLE) && aw_have && w_have;

  // Parked values win over the live channels once taken.
  assign wr_sel = aw_held_ff ? aw_sel_ff : decode(awaddr);
  assign wr_byte = w_held_ff ? wbyte_ff : wdata[7:0];
  assign wr_lane = w_held_ff ? wlane_ff : wstrb[0];

  // Next state of the write handler and its parked request.
  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_aw_held = aw_held_ff;
    nxt_aw_sel = aw_sel_ff;
    nxt_w_held = w_held_ff;
    nxt_wbyte = wbyte_ff;
    nxt_wlane = wlane_ff;
    nxt_bresp = bresp_ff;
    unique case (wr_state_ff)
      WR_IDLE: begin
        if (aw_take) begin
          nxt_aw_held = 1'b1;
          nxt_aw_sel = decode(awaddr);
        end
        if (w_take) begin
          nxt_w_held = 1'b1;
          nxt_wbyte = wdata[7:0];
          nxt_wlane = wstrb[0];
        end
        if (commit) begin
          nxt_aw_held = 1'b0;
          nxt_w_held = 1'b0;
          nxt_bresp = (wr_sel == SEL_NONE) ? `ADC_RESP_SLVERR : `ADC_RESP_OKAY;
          nxt_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          nxt_wr_state = WR_IDLE;
        end
      end
    endcase
  end

  // Registers of the write handler.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_IDLE;
      aw_held_ff <= 1'b0;
      aw_sel_ff <= SEL_NONE;
      w_held_ff <= 1'b0;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bresp_ff <= `ADC_RESP_OKAY;
    end else if (ce) begin
      wr_state_ff <= nxt_wr_state;
      aw_held_ff <= nxt_aw_held;
      aw_sel_ff <= nxt_aw_sel;
      w_held_ff <= nxt_w_held;
      wbyte_ff <= nxt_wbyte;
      wlane_ff <= nxt_wlane;
      bresp_ff <= nxt_bresp;
    end
  end

  // The response stands from register state until the master takes it.
  assign bvalid = (wr_state_ff == WR_RESP);
  assign bresp = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // A software write of one to the start bit in the completion cycle must not be lost.
  assign go_set = commit && wr_lane && (wr_sel == SEL_C0) && wr_byte[`ADC_C0_GO];

  // Control next values; only byte lane 0 carries the 8-bit registers.
  always_comb begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    if (commit && wr_lane && (wr_sel == SEL_C0)) begin
      nxt_ctrl0 = wr_byte;
    end
    if (commit && wr_lane && (wr_sel == SEL_C1)) begin
      nxt_ctrl1 = wr_byte & `ADC_C1_MASK;
    end
    // Completion clears the start bit unless software sets it in the same cycle.
    if (conv_in.done && !go_set) begin
      nxt_ctrl0[`ADC_C0_GO] = 1'b0;
    end
  end

  // Control registers reset to their documented values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_ff <= `ADC_C0_RESET;
      ctrl1_ff <= `ADC_C1_RESET;
    end else if (ce) begin
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
    end
  end

  // The channel field reaches the converter at once; settling time is software's job.
  always_comb begin
    conv_ctrl.enable = ctrl0_ff[`ADC_C0_ENABLE];
    conv_ctrl.go = ctrl0_ff[`ADC_C0_GO];
    conv_ctrl.channel = ctrl0_ff[`ADC_C0_CHAN_HI:`ADC_C0_CHAN_LO];
    conv_ctrl.vref_pos = ctrl0_ff[`ADC_C0_VREF_POS];
    conv_ctrl.vref_neg = ctrl0_ff[`ADC_C0_VREF_NEG];
    conv_ctrl.clk_sel = ctrl1_ff[`ADC_C1_CLKSEL_HI:`ADC_C1_CLKSEL_LO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result bytes.

  // Justification follows the format bit as it stands in the completion cycle.
  result_packer result_packer_inst (
    .value(conv_in.value),
    .right_justify(ctrl0_ff[`ADC_C0_FORMAT]),
    .pair(packed_res)
  );

  // Software may write the bytes, but a completion in the same cycle overrides it.
  always_comb begin
    nxt_res_hi = res_hi_ff;
    nxt_res_lo = res_lo_ff;
    if (commit && wr_lane && (wr_sel == SEL_HI)) begin
      nxt_res_hi = wr_byte;
    end
    if (commit && wr_lane && (wr_sel == SEL_LO)) begin
      nxt_res_lo = wr_byte;
    end
    if (conv_in.done) begin
      nxt_res_hi = packed_res.high;
      nxt_res_lo = packed_res.low;
    end
  end

  // Result bytes carry no reset value; they are unknown until a conversion or a software write fills them.
  always_ff @(posedge aclk) begin
    if (ce) begin
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channels.

  // A new read waits until the last answer is taken; one read at a time keeps the path short.
  assign arready = (rd_state_ff == RD_IDLE);

  // Read data is captured when the address is taken and held until accepted.
  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    unique case (rd_state_ff)
      RD_IDLE: begin
        if (arvalid) begin
          nxt_rd_state = RD_DATA;
          nxt_rresp = `ADC_RESP_OKAY;
          unique case (decode(araddr))
            SEL_C0: nxt_rdata = {24'h000000, ctrl0_ff};
            SEL_C1: nxt_rdata = {24'h000000, ctrl1_ff};
            SEL_HI: nxt_rdata = {24'h000000, res_hi_ff};
            SEL_LO: nxt_rdata = {24'h000000, res_lo_ff};
            default: begin
              nxt_rdata = 32'h00000000;
              nxt_rresp = `ADC_RESP_SLVERR;
            end
          endcase
        end
      end
      RD_DATA: begin
        if (rready) begin
          nxt_rd_state = RD_IDLE;
        end
      end
    endcase
  end

  // Registers of the read handler.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= RD_IDLE;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `ADC_RESP_OKAY;
    end else if (ce) begin
      rd_state_ff <= nxt_rd_state;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // Read answer outputs come straight from the handler's registers.
  assign rvalid = (rd_state_ff == RD_DATA);
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

endmodule // adc_result_formatter

`default_nettype wire

// ---- adc_result_formatter_properties.sv ----
// Concurrent checks on result justification and completion handling of the converter result block.
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_cfg.svh"
module adc_result_formatter_properties #(
  parameter int ADDR_W = 5
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [31:0] rdata,
  // Converter core.
  input wire adc_fmt_pkg::conv_result_t conv_in,
  input wire adc_fmt_pkg::conv_ctrl_t conv_ctrl
);
  import adc_fmt_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Shadow of the format bit and the last result; it assumes address and data arrive together.
  logic fmt_ff, sfmt_ff, ok_ff, nxt_fmt, nxt_sfmt, nxt_ok, wr0, wrr, done, rh, rl;
  logic [9:0] val_ff, nxt_val;
  assign wr0 = ce & awvalid & awready & wvalid & wready & wstrb[0] & (awaddr == `ADC_OFS_CTRL_ZERO);
  // A software write to a result byte makes the shadow stale until the next completion.
  assign wrr = ce & awvalid & awready & wvalid & wready & wstrb[0] &
    ((awaddr == `ADC_OFS_RES_HIGH) | (awaddr == `ADC_OFS_RES_LOW));
  assign done = ce & conv_in.done;
  assign rh = ce & arvalid & arready & ok_ff & (araddr == `ADC_OFS_RES_HIGH);
  assign rl = ce & arvalid & arready & ok_ff & (araddr == `ADC_OFS_RES_LOW);
  assign nxt_fmt = wr0 ? wdata[`ADC_C0_FORMAT] : fmt_ff;
  assign nxt_sfmt = done ? fmt_ff : sfmt_ff;
  assign nxt_val = done ? conv_in.value : val_ff;
  assign nxt_ok = done | (ok_ff & !wrr);
  // Registers of the shadow; the format seen at completion is the one before that edge.
  always_ff @(posedge aclk) begin
    fmt_ff <= aresetn & nxt_fmt;
    ok_ff <= aresetn & nxt_ok;
    sfmt_ff <= nxt_sfmt;
    val_ff <= nxt_val;
  end
  ////////////////////////////////////////
  // Read answers against the shadow, and completion against the start bit.
  property p_left_high;
    rh && !sfmt_ff |=> rdata[7:0] == $past(val_ff[9:2]);
  endproperty
  property p_left_low;
    rl && !sfmt_ff |=> rdata[7:0] == {$past(val_ff[1:0]), 6'h00};
  endproperty
  property p_right_high;
    rh && sfmt_ff |=> rdata[7:0] == {6'h00, $past(val_ff[9:8])};
  endproperty
  property p_right_low;
    rl && sfmt_ff |=> rdata[7:0] == $past(val_ff[7:0]);
  endproperty
  property p_go_clear;
    done && !wr0 |=> !conv_ctrl.go;
  endproperty
  a_left_high: assert property (p_left_high) else $error("High byte wrong, left format.");
  a_left_low: assert property (p_left_low) else $error("Low byte wrong, left format.");
  a_right_high: assert property (p_right_high) else $error("High byte wrong, right format.");
  a_right_low: assert property (p_right_low) else $error("Low byte wrong, right format.");
  a_go_clear: assert property (p_go_clear) else $error("Start bit not cleared.");
  c_left: cover property (rh && !sfmt_ff);
  c_right: cover property (rl && sfmt_ff);
  c_done: cover property (done);
endmodule // adc_result_formatter_properties
bind adc_result_formatter adc_result_formatter_properties #(.ADDR_W(ADDR_W)) adc_result_formatter_properties_inst (
  .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
  .arvalid, .arready, .araddr, .rdata, .conv_in, .conv_ctrl);
`default_nettype wire

// ---- adc_result_formatter_tb.sv ----
// Self-checking bench of the converter result block.
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h want %h", $time, g, e); end end
module adc_result_formatter_tb;
  import adc_fmt_pkg::*;
  // Wait before a start; 120 clocks of 40 ns is longer than the acquisition interval.
  localparam int ACQ = 120;
  localparam int LIMIT = 5000;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] d;
  conv_result_t conv_in;
  conv_ctrl_t conv_ctrl;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  adc_result_formatter adc_result_formatter_inst (.aclk, .aresetn, .ce, .awvalid, .awready,
    .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready(1'b1), .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready(1'b1), .rdata, .rresp,
    .conv_in, .conv_ctrl);
  ////////////////////////////////////////
  // Clock, and a cycle ceiling so that a hung handshake still ends the run.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      conclude();
    end
  end
  task conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus cycles; readies are looked at mid-cycle, as the edge will see them.
  task wr(input logic [4:0] a, input logic [7:0] v);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
  endtask
  task rd(input logic [4:0] a);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
  endtask
  // Channel and format first, the acquisition wait, then the start and one completion pulse.
  task conv(input logic [7:0] c, input logic [9:0] v);
    logic [7:0] go_m;
    go_m = 8'h00;
    go_m[`ADC_C0_GO] = 1'b1;
    wr(`ADC_OFS_CTRL_ZERO, c & ~go_m);
    repeat (ACQ) @(posedge aclk);
    wr(`ADC_OFS_CTRL_ZERO, c | go_m);
    @(negedge aclk);
    `CHK(conv_ctrl.go, 1'b1)
    `CHK(conv_ctrl.channel, c[`ADC_C0_CHAN_HI:`ADC_C0_CHAN_LO])
    @(posedge aclk);
    conv_in <= {1'b1, v};
    @(posedge aclk);
    conv_in <= {1'b0, v};
    @(negedge aclk);
    `CHK(conv_ctrl.go, 1'b0)
    @(posedge aclk);
  endtask
  ////////////////////////////////////////
  // Reset value of converter_control_zero, writable mask and unmapped places.
  task t_regs();
    rd(`ADC_OFS_CTRL_ZERO);
    `CHK(d, `ADC_C0_RESET)
    wr(`ADC_OFS_CTRL_ONE, 8'hFF);
    rd(`ADC_OFS_CTRL_ONE);
    `CHK(d, `ADC_C1_MASK)
    `CHK(conv_ctrl.clk_sel, 3'h7)
    rd(5'h10);
    `CHK(r, `ADC_RESP_SLVERR)
    wr(5'h14, 8'h00);
    `CHK(r, `ADC_RESP_SLVERR)
  endtask
  // Left format, then a format change with no completion must leave the high byte alone.
  task t_left();
    conv(8'h0F, 10'h2D6);
    rd(`ADC_OFS_RES_HIGH);
    `CHK(d, 8'hB5)
    rd(`ADC_OFS_RES_LOW);
    `CHK(d, 8'h80)
    rd(`ADC_OFS_CTRL_ZERO);
    `CHK(d, 8'h0D)
    wr(`ADC_OFS_CTRL_ZERO, 8'h8D);
    rd(`ADC_OFS_RES_HIGH);
    `CHK(d, 8'hB5)
  endtask
  // Right format, then back to left for the next completion.
  task t_right();
    conv(8'h93, 10'h3A5);
    rd(`ADC_OFS_RES_HIGH);
    `CHK(d, 8'h03)
    rd(`ADC_OFS_RES_LOW);
    `CHK(d, 8'hA5)
    conv(8'h13, 10'h001);
    rd(`ADC_OFS_RES_LOW);
    `CHK(d, 8'h40)
  endtask
  // A completion while the clock enable is low must leave the low result byte alone.
  task t_freeze();
    ce <= 1'b0;
    conv_in <= {1'b1, 10'h155};
    @(posedge aclk);
    ce <= 1'b1;
    conv_in <= {1'b0, 10'h155};
    @(posedge aclk);
    rd(`ADC_OFS_RES_LOW);
    `CHK(d, 8'h40)
  endtask
  // Main sequence.
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    conv_in = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_left();
    t_right();
    t_freeze();
    conclude();
  end
endmodule // adc_result_formatter_tb
`default_nettype wire
